// File: anp_top.sv
// Ancillary packet framer: pass-through, placement, captions, host parser
//
// Overview of operation
// [RULE1] Pass packets on configured line, arrival order
// [RULE2] Packets not fitting carry to next line
// [RULE3] Pass buffer holds 250 packets, 1500 bytes
// [RULE4] Unsynced input: drop, never duplicate, ancillary data
// [RULE5] Each type has insertion line, resets 12
// [RULE6] All types VANC; non-SD timecode in HANC
// [RULE7] Same line: lowest insertion order goes first
// [RULE8] 576i subtitle option passes lines 12+; off
// [RULE9] Track caption sequence, reproduce any discontinuity
// [RULE10] 708 output prefers native, else up-converted 608
// [RULE11] 608 output embedded or null; no down-convert
// [RULE12] Caption packet sized per rate for 9600bps
// [RULE13] Timecode inside caption packets is ignored
// [RULE14] CC1 to service 1, CC3 to 2
// [RULE15] Up-converted packets carry 708 plus original 608
// [RULE16] Mark matching VANC packets deleted; per-service enable
// [RULE17] Host packets inserted in both fields; code inserts each packet once, on the first matching line
// [RULE18] Host frames one packet per VANC packet
// [RULE19] Packet starts with two-byte start identifier
// [RULE20] Length byte counts whole packet inclusively
// [RULE21] Payload at most 248 arbitrary bytes
// [RULE22] Footer marker 0x74 then three bytes
// [RULE23] Field indicator bytes 0x31 and 0x32
// [RULE24] Bad footer discards packet, hunt next start
module anp_top
  import anp_pkg::*;
#(
  parameter int PASS_BYTES = PASS_BYTES_DEF,
  parameter int PASS_PKTS = PASS_PKTS_DEF,
  parameter int LINE_CAP = LINE_CAP_DEF,
  parameter int PKT_MAX = PKT_MAX_DEF,
  parameter int NTYPE = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [10:0] line_i,
  input wire logic line_start_i,
  input wire logic frame_start_i,
  input wire logic field2_i,
  input wire logic prog_i,
  input wire logic sd_fmt_i,
  input wire logic out_576i_i,
  input wire logic vblank_i,
  input wire logic sync_i,
  input wire logic frame_drop_i,
  input wire logic frame_rep_i,
  input wire logic pk_vld_i,
  input wire logic [7:0] pk_byte_i,
  input wire logic pk_last_i,
  output logic pk_rdy_o,
  output logic pass_vld_o,
  output logic [7:0] pass_byte_o,
  output logic pass_last_o,
  input wire logic [NTYPE-1:0] type_rdy_i,
  output logic ins_go_o,
  output logic [$clog2(NTYPE)-1:0] ins_type_o,
  output logic ins_hanc_o,
  input wire logic anc_vld_i,
  input wire logic [7:0] anc_did_i,
  input wire logic [7:0] anc_sdid_i,
  input wire logic anc_hanc_i,
  output logic anc_del_o,
  input wire logic cdp_vld_i,
  input wire logic [15:0] cdp_seq_i,
  input wire logic has708_i,
  input wire logic has608_i,
  input wire logic [1:0] cc_chan_i,
  input wire logic [2:0] rate_i,
  output logic cap_disc_o,
  output logic [1:0] cap708_src_o,
  output logic cap608_emb_o,
  output logic cap_both_o,
  output logic [2:0] cc_svc_o,
  output logic [4:0] cc_count_o,
  input wire logic rx_vld_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_rdy_o,
  output logic fi_vld_o,
  output logic [7:0] fi_byte_o,
  output logic hp_vld_o,
  output logic [7:0] hp_byte_o,
  output logic hp_last_o,
  output logic [7:0] hp_did_o,
  output logic [7:0] hp_sdid_o,
  output logic [7:0] hp_len_o,
  output logic vpass_o
);
  localparam int PW = $clog2(PASS_BYTES);
  localparam int TW = $clog2(NTYPE);

  // Byte address of a placement register
  function automatic logic [7:0] type_addr(input int i);
    type_addr = 8'(ADDR_TYPE0 + 4 * i);
  endfunction

  // Circular pointer advance
  function automatic logic [PW-1:0] pnext(input logic [PW-1:0] p);
    pnext = (p == PW'(PASS_BYTES - 1)) ? '0 : p + 1'b1;
  endfunction

  logic [5:0] ctrl_q;
  logic [10:0] pass_line_q;
  logic [7:0] hp_did_q;
  logic [7:0] hp_sdid_q;
  logic [10:0] hp_line_q;
  logic [10:0] tline_q [NTYPE];
  logic [3:0] tord_q [NTYPE];
  logic wr_q;
  logic [7:0] wa_q;
  logic [31:0] hrdata_q;
  logic hrdy_q;
  logic hresp_q;
  logic [31:0] rd_data;
  logic [PW:0] bcnt_q;
  logic [7:0] pkc_q;
  logic hp_full_q;
  logic cap_disc_q;

  // Bus decode; high addresses unmapped
  wire ahb_go = hsel_i & htrans_i[1] & hready_i;
  wire [7:0] ra = (haddr_i[31:8] != 24'h000000) ? ADDR_NONE : haddr_i[7:0];
  wire wr_ctrl = wr_q & (wa_q == ADDR_CTRL);
  wire wr_pass = wr_q & (wa_q == ADDR_PASS);
  wire wr_hp = wr_q & (wa_q == ADDR_HP);
  wire [31:0] stat_w = {10'h000, cap_disc_q, hp_full_q, pkc_q, 12'(bcnt_q)};

  // Read data selection
  always_comb begin
    case (ra)
      ADDR_CTRL: rd_data = {26'h0000000, ctrl_q};
      ADDR_PASS: rd_data = {21'h000000, pass_line_q};
      ADDR_HP: rd_data = {5'h00, hp_line_q, hp_sdid_q, hp_did_q};
      ADDR_STAT: rd_data = stat_w;
      default: rd_data = 32'h00000000;
    endcase
    for (int i = 0; i < NTYPE; i++) begin
      if (ra == type_addr(i)) begin
        rd_data = {12'h000, tord_q[i], 5'h00, tline_q[i]};
      end
    end
  end

  // Bus slave: zero wait states, always OKAY
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
      hrdata_q <= 32'h00000000;
      hrdy_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      wr_q <= ahb_go & hwrite_i;
      hrdy_q <= 1'b1;
      hresp_q <= 1'b0;
      if (ahb_go) begin
        wa_q <= ra;
      end
      if (ahb_go & ~hwrite_i) begin
        hrdata_q <= rd_data;
      end
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= CTRL_RST; // RULE8 RULE16
      pass_line_q <= LINE_RST;
      hp_did_q <= 8'h00;
      hp_sdid_q <= 8'h00;
      hp_line_q <= LINE_RST;
      for (int i = 0; i < NTYPE; i++) begin
        tline_q[i] <= LINE_RST; // RULE5
        tord_q[i] <= 4'(i);
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= hwdata_i[5:0];
      end
      if (wr_pass) begin
        pass_line_q <= hwdata_i[10:0];
      end
      if (wr_hp) begin
        hp_did_q <= hwdata_i[7:0];
        hp_sdid_q <= hwdata_i[15:8];
        hp_line_q <= hwdata_i[26:16];
      end
      for (int i = 0; i < NTYPE; i++) begin
        if (wr_q && wa_q == type_addr(i)) begin
          tline_q[i] <= hwdata_i[10:0]; // RULE5
          tord_q[i] <= hwdata_i[19:16];
        end
      end
    end
  end

  // Pass buffer: byte and end flag
  logic [8:0] pbuf [PASS_BYTES]; // RULE3
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [PW-1:0] ps0_q;
  logic [PW:0] part_q;
  logic [15:0] bud_q;
  logic pact_q;
  logic inpk_q;
  logic carry_q;
  logic rep_q;
  logic pk_rdy_q;
  logic pass_vld_q;
  logic pass_last_q;
  logic [7:0] pass_byte_q;

  wire pin = pk_vld_i & pk_rdy_q & ctrl_q[CB_PASS];
  wire pin_end = pin & pk_last_i;
  wire flush = frame_drop_i & ~sync_i;
  wire pline = carry_q | (line_i == pass_line_q);
  wire pstart = line_start_i & ctrl_q[CB_PASS] & vblank_i & ~rep_q & pline;
  wire pfit = (pkc_q != 8'h00) & (bud_q >= 16'(PKT_MAX));
  wire pgo = pact_q & (inpk_q | pfit);
  wire pout = pgo & ~flush;
  wire [8:0] pword = pbuf[rp_q];
  wire pend_pk = pout & pword[8];

  // Buffer storage in arrival order
  always_ff @(posedge clk_i) begin
    if (pin) begin
      pbuf[wp_q] <= {pk_last_i, pk_byte_i}; // RULE1
    end
  end

  // Pass emission and line carry
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q <= '0;
      rp_q <= '0;
      ps0_q <= '0;
      part_q <= '0;
      bcnt_q <= '0;
      pkc_q <= 8'h00;
      bud_q <= 16'h0000;
      pact_q <= 1'b0;
      inpk_q <= 1'b0;
      carry_q <= 1'b0;
      rep_q <= 1'b0;
      pk_rdy_q <= 1'b0;
      pass_vld_q <= 1'b0;
      pass_last_q <= 1'b0;
      pass_byte_q <= 8'h00;
    end else begin
      pk_rdy_q <= (bcnt_q < (PW + 1)'(PASS_BYTES - 2)) & (pkc_q < 8'(PASS_PKTS - 1)); // RULE3
      pass_vld_q <= pout;
      pass_last_q <= pend_pk;
      if (pout) begin
        pass_byte_q <= pword[7:0]; // RULE1
        inpk_q <= ~pword[8];
      end
      if (pin) begin
        wp_q <= pnext(wp_q);
        part_q <= pk_last_i ? '0 : part_q + 1'b1;
      end
      if (pin_end) begin
        ps0_q <= pnext(wp_q);
      end
      if (frame_start_i) begin
        rep_q <= frame_rep_i & ~sync_i; // RULE4
      end
      if (flush) begin
        rp_q <= pin_end ? pnext(wp_q) : ps0_q; // RULE4
        bcnt_q <= pin_end ? '0 : part_q + (PW + 1)'(pin);
        pkc_q <= 8'h00;
        pact_q <= 1'b0;
        inpk_q <= 1'b0;
        carry_q <= 1'b0;
      end else begin
        if (pout) begin
          rp_q <= pnext(rp_q);
        end
        bcnt_q <= bcnt_q + (PW + 1)'(pin) - (PW + 1)'(pout);
        pkc_q <= pkc_q + 8'(pin_end) - 8'(pend_pk);
        if (pstart) begin
          pact_q <= 1'b1;
          carry_q <= 1'b0;
          bud_q <= 16'(LINE_CAP);
        end else if (pact_q & ~pgo) begin
          pact_q <= 1'b0;
          carry_q <= pkc_q != 8'h00; // RULE2
        end else if (pout && bud_q != 16'h0000) begin
          bud_q <= bud_q - 16'h0001;
        end
      end
    end
  end

  // Lowest order pending type
  logic [NTYPE-1:0] tpend_q;
  logic [TW-1:0] pk_idx;
  logic pk_any;
  logic [3:0] pk_ord;
  always_comb begin
    pk_idx = '0;
    pk_any = 1'b0;
    pk_ord = 4'hF;
    for (int i = 0; i < NTYPE; i++) begin
      if (tpend_q[i] && (!pk_any || tord_q[i] < pk_ord)) begin
        pk_any = 1'b1; // RULE7
        pk_idx = TW'(i);
        pk_ord = tord_q[i];
      end
    end
  end

  // Specific packet placement
  logic ins_go_q;
  logic [TW-1:0] ins_type_q;
  logic ins_hanc_q;
  wire tc_hanc = ~sd_fmt_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tpend_q <= '0;
      ins_go_q <= 1'b0;
      ins_type_q <= '0;
      ins_hanc_q <= 1'b0;
    end else begin
      ins_go_q <= 1'b0;
      if (line_start_i) begin
        for (int i = 0; i < NTYPE; i++) begin
          tpend_q[i] <= type_rdy_i[i] & (tline_q[i] == line_i)
                        & (vblank_i | (i == TC_TYPE && tc_hanc)); // RULE5 RULE6
        end
      end else if (pk_any) begin
        tpend_q[pk_idx] <= 1'b0;
        ins_go_q <= 1'b1; // RULE7
        ins_type_q <= pk_idx;
        ins_hanc_q <= (pk_idx == TW'(TC_TYPE)) & tc_hanc; // RULE6
      end
    end
  end

  // Subtitle window, deletion marks
  logic vpass_q;
  logic anc_del_q;
  wire hit_hp = ctrl_q[CB_DELHP] & (anc_did_i == hp_did_q) & (anc_sdid_i == hp_sdid_q);
  wire hit_cap = ctrl_q[CB_DELCAP] & (anc_did_i == CAP_DID) & (anc_sdid_i == CAP_SDID);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      vpass_q <= 1'b0;
      anc_del_q <= 1'b0;
    end else begin
      vpass_q <= ctrl_q[CB_SUB] & out_576i_i & vblank_i & (line_i >= SUB_LINE0); // RULE8
      anc_del_q <= anc_vld_i & ~anc_hanc_i & (hit_hp | hit_cap); // RULE16
    end
  end

  // Caption pairs per packet
  logic [4:0] cc_n;
  always_comb begin
    case (rate_i)
      FR_24: cc_n = 5'(CC_PAIRS_PER_S / 24); // RULE12
      FR_25: cc_n = 5'(CC_PAIRS_PER_S / 25);
      FR_30: cc_n = 5'(CC_PAIRS_PER_S / 30);
      FR_50: cc_n = 5'(CC_PAIRS_PER_S / 50);
      FR_60: cc_n = 5'(CC_PAIRS_PER_S / 60);
      default: cc_n = 5'(CC_PAIRS_PER_S / 30);
    endcase
  end

  // Caption source and sequence flags
  logic [15:0] seq_q;
  logic seq_ok_q;
  anp_c708_type c708_q;
  logic c608_q;
  logic both_q;
  logic [2:0] svc_q;
  logic [4:0] ccn_q;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seq_q <= 16'h0000;
      seq_ok_q <= 1'b0;
      cap_disc_q <= 1'b0;
      c708_q <= C7_NONE;
      c608_q <= 1'b0;
      both_q <= 1'b0;
      svc_q <= SVC_NONE;
      ccn_q <= 5'h00;
    end else if (cdp_vld_i) begin
      seq_q <= cdp_seq_i; // RULE13
      seq_ok_q <= 1'b1;
      cap_disc_q <= seq_ok_q & (cdp_seq_i != seq_q + 16'h0001); // RULE9
      c708_q <= has708_i ? C7_NATIVE : (has608_i ? C7_UPCONV : C7_NONE); // RULE10
      c608_q <= has608_i; // RULE11
      both_q <= ~has708_i & has608_i; // RULE15
      svc_q <= (cc_chan_i == 2'h0) ? SVC1 : ((cc_chan_i == 2'h2) ? SVC2 : SVC_NONE); // RULE14
      ccn_q <= cc_n; // RULE12
    end
  end

  // Host packet parser
  anp_ps_type ps_q;
  logic [7:0] dlen_q;
  logic [7:0] didx_q;
  logic [1:0] fcnt_q;
  logic rx_rdy_q;
  logic [7:0] hmem [HP_DATA_MAX];
  wire rx_take = rx_vld_i & rx_rdy_q;
  wire pdone = rx_take & (ps_q == PS_FDAT) & (fcnt_q == FTR_N - 2'h1);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ps_q <= PS_ID0;
      dlen_q <= 8'h00;
      didx_q <= 8'h00;
      fcnt_q <= 2'h0;
    end else if (rx_take) begin
      case (ps_q)
        PS_ID0: begin
          if (rx_byte_i == START_ID0) begin
            ps_q <= PS_ID1; // RULE19
          end
        end
        PS_ID1: begin
          if (rx_byte_i == START_ID1) begin
            ps_q <= PS_LEN; // RULE19
          end else if (rx_byte_i != START_ID0) begin
            ps_q <= PS_ID0;
          end
        end
        PS_LEN: begin
          dlen_q <= rx_byte_i - HDR_LEN; // RULE20 RULE21
          didx_q <= 8'h00;
          if (rx_byte_i < HDR_LEN) begin
            ps_q <= PS_ID0;
          end else if (rx_byte_i == HDR_LEN) begin
            ps_q <= PS_FTR;
          end else begin
            ps_q <= PS_DAT;
          end
        end
        PS_DAT: begin
          didx_q <= didx_q + 8'h01;
          if (didx_q == dlen_q - 8'h01) begin
            ps_q <= PS_FTR; // RULE18
          end
        end
        PS_FTR: begin
          fcnt_q <= 2'h0;
          ps_q <= (rx_byte_i == FOOTER) ? PS_FDAT : PS_ID0; // RULE22 RULE24
        end
        PS_FDAT: begin
          fcnt_q <= fcnt_q + 2'h1;
          if (fcnt_q == FTR_N - 2'h1) begin
            ps_q <= PS_ID0; // RULE22
          end
        end
        default: ps_q <= PS_ID0;
      endcase
    end
  end

  // Payload store
  always_ff @(posedge clk_i) begin
    if (rx_take && ps_q == PS_DAT) begin
      hmem[didx_q] <= rx_byte_i; // RULE21
    end
  end

  // Host packet insertion
  logic hp_act_q;
  logic [7:0] hrd_q;
  logic hp_vld_q;
  logic hp_last_q;
  logic [7:0] hp_byte_q;
  wire hp_end = hp_act_q & ((dlen_q == 8'h00) | (hrd_q == dlen_q - 8'h01));
  wire hp_start = line_start_i & hp_full_q & ~hp_act_q & ctrl_q[CB_HPEN] & vblank_i
                  & (line_i == hp_line_q);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hp_full_q <= 1'b0;
      hp_act_q <= 1'b0;
      hrd_q <= 8'h00;
      hp_vld_q <= 1'b0;
      hp_last_q <= 1'b0;
      hp_byte_q <= 8'h00;
      rx_rdy_q <= 1'b0;
    end else begin
      rx_rdy_q <= ~(hp_full_q & ~hp_end) & ~pdone;
      hp_vld_q <= hp_act_q;
      hp_last_q <= hp_end;
      if (pdone) begin
        hp_full_q <= 1'b1;
      end
      if (hp_start) begin
        hp_act_q <= 1'b1; // RULE17
        hrd_q <= 8'h00;
      end
      if (hp_act_q) begin
        hp_byte_q <= hmem[hrd_q];
        hrd_q <= hrd_q + 8'h01;
        if (hp_end) begin
          hp_act_q <= 1'b0;
          hp_full_q <= 1'b0;
        end
      end
    end
  end

  // Field indicator, toggled when progressive
  logic fi_vld_q;
  logic [7:0] fi_byte_q;
  logic tog_q;
  wire fsel = prog_i ? tog_q : field2_i;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fi_vld_q <= 1'b0;
      fi_byte_q <= 8'h00;
      tog_q <= 1'b0;
    end else begin
      fi_vld_q <= frame_start_i & ctrl_q[CB_FI];
      if (frame_start_i) begin
        fi_byte_q <= fsel ? FI2 : FI1; // RULE23
        tog_q <= prog_i ? ~tog_q : 1'b0;
      end
    end
  end

  // Registered outputs
  assign hrdata_o = hrdata_q;
  assign hreadyout_o = hrdy_q;
  assign hresp_o = hresp_q;
  assign pk_rdy_o = pk_rdy_q;
  assign pass_vld_o = pass_vld_q;
  assign pass_byte_o = pass_byte_q;
  assign pass_last_o = pass_last_q;
  assign ins_go_o = ins_go_q;
  assign ins_type_o = ins_type_q;
  assign ins_hanc_o = ins_hanc_q;
  assign anc_del_o = anc_del_q;
  assign cap_disc_o = cap_disc_q;
  assign cap708_src_o = c708_q;
  assign cap608_emb_o = c608_q;
  assign cap_both_o = both_q;
  assign cc_svc_o = svc_q;
  assign cc_count_o = ccn_q;
  assign rx_rdy_o = rx_rdy_q;
  assign fi_vld_o = fi_vld_q;
  assign fi_byte_o = fi_byte_q;
  assign hp_vld_o = hp_vld_q;
  assign hp_byte_o = hp_byte_q;
  assign hp_last_o = hp_last_q;
  assign hp_did_o = hp_did_q;
  assign hp_sdid_o = hp_sdid_q;
  assign hp_len_o = dlen_q;
  assign vpass_o = vpass_q;
endmodule

// File: anp_pkg.sv
// Package: constants and types of the ancillary packet framer
package anp_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PASS = 8'h04;
  localparam logic [7:0] ADDR_HP = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_TYPE0 = 8'h10;
  localparam logic [7:0] ADDR_NONE = 8'hFF;
  // Control bits
  localparam int CB_PASS = 0;
  localparam int CB_SUB = 1;
  localparam int CB_FI = 2;
  localparam int CB_DELHP = 3;
  localparam int CB_DELCAP = 4;
  localparam int CB_HPEN = 5;
  // Reset values
  localparam logic [5:0] CTRL_RST = 6'h18;
  localparam logic [10:0] LINE_RST = 11'h00C;
  localparam logic [10:0] SUB_LINE0 = 11'h00C;
  // Pass-through buffer sizing
  localparam int PASS_BYTES_DEF = 1500;
  localparam int PASS_PKTS_DEF = 250;
  localparam int LINE_CAP_DEF = 1024;
  localparam int PKT_MAX_DEF = 262;
  // Host framing; start ids arbitrary
  localparam logic [7:0] START_ID0 = 8'hA5;
  localparam logic [7:0] START_ID1 = 8'h5A;
  localparam logic [7:0] FOOTER = 8'h74;
  localparam logic [7:0] HDR_LEN = 8'h07;
  localparam logic [1:0] FTR_N = 2'h3;
  localparam int HP_DATA_MAX = 248;
  // Field indicator bytes
  localparam logic [7:0] FI1 = 8'h31;
  localparam logic [7:0] FI2 = 8'h32;
  // Caption service identity and mapping
  localparam logic [7:0] CAP_DID = 8'h61;
  localparam logic [7:0] CAP_SDID = 8'h01;
  localparam logic [2:0] SVC_NONE = 3'h0;
  localparam logic [2:0] SVC1 = 3'h1;
  localparam logic [2:0] SVC2 = 3'h2;
  localparam int TC_TYPE = 0;
  // Caption channel rate and pairs per second
  localparam int CC_BPS = 9600;
  localparam int CC_PAIRS_PER_S = CC_BPS / 16;
  typedef enum logic [2:0] {
    PS_ID0 = 3'b000, PS_ID1 = 3'b001, PS_LEN = 3'b010,
    PS_DAT = 3'b011, PS_FTR = 3'b100, PS_FDAT = 3'b101
  } anp_ps_type;
  typedef enum logic [2:0] {
    FR_24 = 3'b000, FR_25 = 3'b001, FR_30 = 3'b010, FR_50 = 3'b011, FR_60 = 3'b100
  } anp_rate_type;
  typedef enum logic [1:0] {
    C7_NONE = 2'b00, C7_NATIVE = 2'b01, C7_UPCONV = 2'b10
  } anp_c708_type;
endpackage

// File: anp_host.sv
// Transmit computer model
module anp_host
  import anp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rdy_i,
  output logic vld_o,
  output logic [7:0] byte_o
);
  initial {vld_o, byte_o} = 9'h000;
  // One frame; bad spoils footer marker
  task automatic send(input logic [7:0] len, input logic bad, input logic [7:0] base);
    logic [7:0] b;
    int n;
    for (int i = 0; i < len; i++) begin
      if (i < 3) b = i == 0 ? START_ID0 : i == 1 ? START_ID1 : len;
      else if (i < len - 4) b = base + 8'((i - 3) * 7);
      else if (i == len - 4) b = bad ? 8'h00 : FOOTER;
      else b = 8'hC0 + 8'(i);
      vld_o <= 1'h1;
      byte_o <= b;
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (rdy_i !== 1'h1 && n < 400);
      @(posedge clk_i);
    end
    vld_o <= 1'h0;
    byte_o <= ~b; // Released line shows no stale byte
  endtask
endmodule

// File: anp_top_checker.sv
// Properties of the ancillary packet framer
module anp_top_checker
  import anp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic anc_vld_i,
  input wire logic anc_hanc_i,
  input wire logic anc_del_o,
  input wire logic cdp_vld_i,
  input wire logic [15:0] cdp_seq_i,
  input wire logic has708_i,
  input wire logic has608_i,
  input wire logic [1:0] cc_chan_i,
  input wire logic [2:0] rate_i,
  input wire logic cap_disc_o,
  input wire logic [1:0] cap708_src_o,
  input wire logic cap608_emb_o,
  input wire logic cap_both_o,
  input wire logic [2:0] cc_svc_o,
  input wire logic [4:0] cc_count_o,
  input wire logic frame_start_i,
  input wire logic field2_i,
  input wire logic prog_i,
  input wire logic fi_vld_o,
  input wire logic [7:0] fi_byte_o,
  input wire logic out_576i_i,
  input wire logic vblank_i,
  input wire logic [10:0] line_i,
  input wire logic vpass_o
);
  logic [15:0] seq_q;
  logic seen_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Last caption sequence number seen
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) {seen_q, seq_q} <= 17'h00000;
    else if (cdp_vld_i) {seen_q, seq_q} <= {1'h1, cdp_seq_i};
  end
  property p_disc;
    cdp_vld_i && seen_q |=> cap_disc_o == ($past(cdp_seq_i) != $past(seq_q) + 16'h1);
  endproperty
  a_disc: assert property (p_disc) else $error("caption gap flag wrong");
  property p_src;
    cdp_vld_i |=> cap708_src_o == ($past(has708_i) ? C7_NATIVE : $past(has608_i) ? C7_UPCONV : C7_NONE);
  endproperty
  a_src: assert property (p_src) else $error("708 source wrong");
  property p_emb;
    cdp_vld_i |=> cap608_emb_o == $past(has608_i);
  endproperty
  a_emb: assert property (p_emb) else $error("608 output source wrong");
  property p_cnt;
    cdp_vld_i |=> cc_count_o == ($past(rate_i) == FR_24 ? 5'h19 : $past(rate_i) == FR_25 ? 5'h18 :
      $past(rate_i) == FR_30 ? 5'h14 : $past(rate_i) == FR_50 ? 5'h0C : 5'h0A);
  endproperty
  a_cnt: assert property (p_cnt) else $error("caption pair count wrong");
  property p_svc;
    cdp_vld_i && !has708_i && has608_i |=>
      cc_svc_o == ($past(cc_chan_i) == 2'h0 ? SVC1 : $past(cc_chan_i) == 2'h2 ? SVC2 : SVC_NONE);
  endproperty
  a_svc: assert property (p_svc) else $error("caption service map wrong");
  property p_both;
    cdp_vld_i |=> cap_both_o == (!$past(has708_i) && $past(has608_i));
  endproperty
  a_both: assert property (p_both) else $error("both-format embed wrong");
  property p_del;
    anc_del_o |-> $past(anc_vld_i) && !$past(anc_hanc_i);
  endproperty
  a_del: assert property (p_del) else $error("bad deletion mark");
  property p_fi;
    fi_vld_o && !$past(prog_i) |-> $past(frame_start_i) && fi_byte_o == ($past(field2_i) ? FI2 : FI1);
  endproperty
  a_fi: assert property (p_fi) else $error("field indicator wrong");
  property p_vpass;
    vpass_o |-> $past(out_576i_i && vblank_i && line_i >= 11'h00C);
  endproperty
  a_vpass: assert property (p_vpass) else $error("vpass outside window");
endmodule
bind anp_top anp_top_checker u_chk (.*);

// File: anp_top_tb.sv
// Testbench of the ancillary packet framer
module anp_top_tb import anp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, hsel_i, hwrite_i, line_start_i, frame_start_i, field2_i, prog_i, sd_fmt_i, sync_i;
  logic out_576i_i, vblank_i, frame_drop_i, frame_rep_i, pk_vld_i, pk_last_i, anc_vld_i, anc_hanc_i;
  logic cdp_vld_i, has708_i, has608_i, rx_vld_i, hreadyout_o, hresp_o, pk_rdy_o, pass_vld_o, pass_last_o;
  logic ins_go_o, ins_hanc_o, anc_del_o, cap_disc_o, cap608_emb_o, cap_both_o, rx_rdy_o, fi_vld_o;
  logic hp_vld_o, hp_last_o, vpass_o;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  logic [1:0] htrans_i, cc_chan_i, ins_type_o, cap708_src_o;
  logic [2:0] hsize_i, rate_i, cc_svc_o;
  logic [4:0] cc_count_o;
  logic [10:0] line_i;
  logic [7:0] pk_byte_i, anc_did_i, anc_sdid_i, rx_byte_i, pass_byte_o, fi_byte_o;
  logic [7:0] hp_byte_o, hp_did_o, hp_sdid_o, hp_len_o, len;
  logic [3:0] type_rdy_i;
  logic [15:0] cdp_seq_i;
  logic [8:0] q_pass[$], q_hp[$];
  logic [1:0] q_ins[$];
  int error_cnt = 0, compares = 0, seed = 50040, n;
  wire hready_i = hreadyout_o;
  anp_top #(.PASS_BYTES(64), .PASS_PKTS(8), .LINE_CAP(300)) dut (.*);
  anp_host u_host (.clk_i(clk_i), .rdy_i(rx_rdy_o), .vld_o(rx_vld_i), .byte_o(rx_byte_i));
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done;
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  function automatic logic [7:0] pay(input logic [7:0] base, input int k);
    return base + 8'(k * 7);
  endfunction
  // Bounded wait on ready or drain
  task automatic wt(input int k);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((k == 2 ? q_pass.size() + q_hp.size() + q_ins.size() == 0 : k ? pk_rdy_o : hreadyout_o) !== 1'h1 && n < 400);
    if (n >= 400) begin
      error_cnt++;
      test_done;
    end
    @(posedge clk_i);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel_i <= 1'h1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    wt(0);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    wt(0);
    rd = hrdata_o;
  endtask
  task automatic ls(input logic [10:0] l);
    line_i <= l;
    vblank_i <= 1'h1;
    line_start_i <= 1'h1;
    @(posedge clk_i);
    line_start_i <= 1'h0;
  endtask
  task automatic drain;
    wt(2);
    repeat (4) @(posedge clk_i);
  endtask
  task automatic del(input logic [7:0] d, input logic [7:0] s, input logic e);
    anc_vld_i <= 1'h1;
    anc_did_i <= d;
    anc_sdid_i <= s;
    @(posedge clk_i);
    anc_vld_i <= 1'h0;
    @(negedge clk_i);
    chk("del", e, anc_del_o);
    @(posedge clk_i);
  endtask
  task automatic hp_run(input logic [7:0] l, input logic [7:0] base);
    for (int k = 0; k < l - 7; k++) q_hp.push_back({k == l - 8, pay(base, k)});
    u_host.send(l, 1'h0, base);
    ls(11'h014);
    drain;
    chk("hlen", l - 8'h07, hp_len_o);
    chk("hdid", 8'h12, hp_did_o);
  endtask
  // Output streams vs queues
  always @(negedge clk_i) begin
    if (pass_vld_o === 1'h1) chk("pass", q_pass.pop_front(), {pass_last_o, pass_byte_o});
    if (hp_vld_o === 1'h1) chk("host", q_hp.pop_front(), {hp_last_o, hp_byte_o});
    if (ins_go_o === 1'h1) chk("ins", q_ins.pop_front(), ins_type_o);
  end
  initial begin
    {hsel_i, hwrite_i, line_start_i, frame_start_i, field2_i, prog_i, sd_fmt_i, out_576i_i, vblank_i,
      frame_drop_i, frame_rep_i, pk_vld_i, pk_last_i, anc_vld_i, anc_hanc_i, cdp_vld_i, has708_i, has608_i,
      haddr_i, hwdata_i, htrans_i, cc_chan_i, rate_i, line_i, pk_byte_i, anc_did_i, anc_sdid_i,
      type_rdy_i, cdp_seq_i} = '0;
    sync_i = 1'h1;
    hsize_i = 3'h2;
    rst_i = 1'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    ahb(0, ADDR_CTRL, 0);
    chk("ctrl", 32'h18, rd);
    ahb(0, ADDR_PASS, 0);
    chk("pass", 32'h0C, rd);
    ahb(0, ADDR_TYPE0 + 4, 0);
    chk("type", 32'h0001000C, rd);
    ahb(0, 32'h100, 0);
    chk("unmap", 0, rd);
    ahb(1, ADDR_HP, 32'h00143412);
    for (int i = 0; i < 4; i++) begin
      if (i == 2) ahb(1, ADDR_CTRL, 32'h21);
      del(i[0] ? CAP_DID : 8'h12, i[0] ? CAP_SDID : 8'h34, i < 2);
    end
    for (int i = 0; i < 43; i++) begin
      q_pass.push_back({i == 39 || i == 42, 8'(i)});
      pk_vld_i <= 1'h1;
      pk_byte_i <= 8'(i);
      pk_last_i <= i == 39 || i == 42;
      wt(1);
    end
    pk_vld_i <= 1'h0;
    ls(11'h00C);
    repeat (60) @(posedge clk_i);
    chk("carry", 3, q_pass.size());
    ls(11'h00D);
    drain;
    ahb(1, ADDR_TYPE0, 32'h0005000C);
    ahb(1, ADDR_TYPE0 + 12, 32'h0000000C);
    q_ins = '{2'h3, 2'h1, 2'h2, 2'h0};
    type_rdy_i <= 4'hF;
    sd_fmt_i <= 1'h1;
    ls(11'h00C);
    drain;
    type_rdy_i <= 4'h0;
    hp_run(8'h08, 8'h01);
    u_host.send(8'h0C, 1'h1, 8'h40);
    hp_run(8'hFF, 8'h99);
    repeat (3) begin
      len = 8'h08 + 8'($random(seed) & 63);
      hp_run(len, 8'($random(seed)));
    end
    ahb(1, ADDR_CTRL, 32'h1E);
    anc_did_i <= CAP_DID;
    anc_sdid_i <= CAP_SDID;
    repeat (3000) begin
      {cdp_vld_i, has708_i, has608_i, anc_vld_i, anc_hanc_i, field2_i, prog_i, out_576i_i} <= 8'($random(seed));
      {vblank_i, sd_fmt_i, cc_chan_i} <= 4'($random(seed));
      frame_start_i <= ($random(seed) & 15) == 0;
      rate_i <= 3'($unsigned($random(seed)) % 5);
      line_i <= 11'($random(seed) & 31);
      if (cdp_vld_i) cdp_seq_i <= cdp_seq_i + 16'h1 + 16'(($random(seed) & 7) == 0);
      @(posedge clk_i);
    end
    test_done;
  end
endmodule
